/* File: core/adc_meas_cfg.svh */
// constants for the measurement configuration block
// assumes inclusion by the modules only; the package does not include it
`ifndef ADC_MEAS_CFG_SVH
`define ADC_MEAS_CFG_SVH
// register offsets are word indices, byte address is four times the index
`define OFS_PROX_GAIN 32'h0000_000B
`define OFS_PROX_MISC 32'h0000_000C
`define OFS_AMB_IR_SEL 32'h0000_000E
`define OFS_AUX_SEL 32'h0000_000F
`define OFS_VIS_REC 32'h0000_0010
`define OFS_VIS_GAIN 32'h0000_0011
`define OFS_MEAS_CTRL 32'h0000_0014
`define OFS_MEAS_STAT 32'h0000_0018
`define RST_PROX_GAIN 8'h00
`define RST_PROX_MISC 8'h04
`define RST_AMB_IR_SEL 8'h00
`define RST_AUX_SEL 8'h65
`define RST_VIS_REC 8'h70
`define RST_VIS_GAIN 8'h00
`define BIT_PROX_RANGE 5
`define BIT_PROX_MODE 2
`define VIS_REC_LSB 4
`define AMB_IR_SMALL 8'h00
`define AMB_IR_LARGE 8'h03
`define AUX_TEMP 8'h65
`define AUX_VDD 8'h75
`define ADC_TICK_NS 50
`define CLK_NS 25
// 50 ns base tick rounded down to whole 25 ns cycles, at least one
`define ADC_TICK_CYC ((`ADC_TICK_NS / `CLK_NS) < 1 ? 1 : (`ADC_TICK_NS / `CLK_NS))
`define BASE_INTEG_CLKS 16'h0010
`endif

/* File: core/adc_meas_pkg.sv */
// types shared by the measurement configuration block
// assumes adc_meas_cfg.svh holds the numbers
package adc_meas_pkg;
  typedef enum logic [1:0] {MEAS_PROX, MEAS_VIS, MEAS_IR, MEAS_AUX} meas_kind_t;
  typedef struct packed {
    logic [2:0] gain_exp;
    logic high_range;
    logic normal_mode;
    logic emitter_on;
    logic [7:0] input_code;
  } adc_setup_t;
endpackage

/* File: core/adc_tick_timer.sv */
// counts a number of adc clocks, each adc clock stretched by 2^exp
// assumes start is a one-cycle pulse, given while idle or on the done cycle
`timescale 1ns/1ps
`include "adc_meas_cfg.svh"
module adc_tick_timer #(
  parameter int CNT_W = 24
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic [9:0] clocks_i,
  input wire logic [2:0] exp_i,
  output logic busy_o,
  output logic done_o
);
  localparam int TICK = `ADC_TICK_CYC;
  logic [CNT_W-1:0] cnt_q;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= '0;
    end else begin
      if (start_i) begin
        cnt_q <= CNT_W'((clocks_i * TICK) << exp_i);
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - CNT_W'(1);
      end
    end
  end
  // last counted cycle, so a run lasts exactly the programmed cycles
  assign done_o = (cnt_q == CNT_W'(1));
  assign busy_o = (cnt_q != '0);
endmodule // adc_tick_timer

/* File: core/adc_meas_ctrl.sv */
// measurement configuration registers and sequencer over ahb-lite
// assumes a single-master ahb-lite bus, word transfers only
`timescale 1ns/1ps
`include "adc_meas_cfg.svh"
module adc_meas_ctrl
  import adc_meas_pkg::*;
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // ahb-lite slave
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // adc front end
  output adc_setup_t ADC_SETUP_O,
  output logic ADC_CONVERT_O,
  output logic [1:0] ADC_KIND_O
);
  typedef enum {ST_IDLE, ST_RECOVER, ST_INTEG, ST_NEXT} seq_state_t;

  logic [2:0] prox_gain_q;
  logic prox_range_q;
  logic prox_mode_q;
  logic [7:0] amb_ir_q;
  logic [7:0] aux_q;
  logic [2:0] vis_rec_q;
  logic [2:0] vis_gain_q;
  logic [3:0] kind_en_q;
  logic start_q;
  logic wr_pend_q;
  logic [31:0] wr_addr_q;
  logic [31:0] rd_data_d;
  logic [31:0] rd_data_q;
  seq_state_t state_q;
  meas_kind_t kind_q;
  adc_setup_t setup_q;
  logic [1:0] done_cnt_q;
  logic tmr_start;
  logic [9:0] tmr_clocks;
  logic [2:0] tmr_exp;
  logic tmr_busy;
  logic tmr_done;
  logic addr_phase;

  // 2^(n+2)-1 adc clocks for recovery code n, code zero gives one
  function automatic logic [9:0] rec_clocks(input logic [2:0] code);
    rec_clocks = (code == 3'h0) ? 10'h001 : 10'((10'h001 << (4'(code) + 4'h2)) - 10'h001);
  endfunction

  // one word per register, byte address four times the index
  function automatic logic reg_hit(input logic [31:0] addr, input logic [31:0] idx);
    reg_hit = (addr == {idx[29:0], 2'b00});
  endfunction

  assign addr_phase = HSEL_I && HREADY_I && HTRANS_I[1];

  // write address captured in address phase, data taken next cycle
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_phase && HWRITE_I;
      if (addr_phase) begin
        wr_addr_q <= HADDR_I;
      end
    end
  end

  // configuration registers, reserved bits dropped
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      prox_gain_q <= 3'(`RST_PROX_GAIN);
      prox_range_q <= 1'(`RST_PROX_MISC >> `BIT_PROX_RANGE);
      prox_mode_q <= 1'(`RST_PROX_MISC >> `BIT_PROX_MODE);
      amb_ir_q <= `RST_AMB_IR_SEL;
      aux_q <= `RST_AUX_SEL;
      vis_rec_q <= 3'(`RST_VIS_REC >> `VIS_REC_LSB);
      vis_gain_q <= 3'(`RST_VIS_GAIN);
      kind_en_q <= 4'h0;
    end else if (wr_pend_q) begin
      if (reg_hit(wr_addr_q, `OFS_PROX_GAIN)) begin
        prox_gain_q <= HWDATA_I[2:0];
      end else if (reg_hit(wr_addr_q, `OFS_PROX_MISC)) begin
        prox_range_q <= HWDATA_I[`BIT_PROX_RANGE];
        prox_mode_q <= HWDATA_I[`BIT_PROX_MODE];
      end else if (reg_hit(wr_addr_q, `OFS_AMB_IR_SEL)) begin
        amb_ir_q <= HWDATA_I[7:0];
      end else if (reg_hit(wr_addr_q, `OFS_AUX_SEL)) begin
        aux_q <= HWDATA_I[7:0];
      end else if (reg_hit(wr_addr_q, `OFS_VIS_REC)) begin
        vis_rec_q <= HWDATA_I[`VIS_REC_LSB+2:`VIS_REC_LSB];
      end else if (reg_hit(wr_addr_q, `OFS_VIS_GAIN)) begin
        vis_gain_q <= HWDATA_I[2:0];
      end else if (reg_hit(wr_addr_q, `OFS_MEAS_CTRL)) begin
        kind_en_q <= HWDATA_I[3:0];
      end
    end
  end

  // start pulse from a write of bit 8 of the control word
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      start_q <= 1'b0;
    end else begin
      start_q <= wr_pend_q && reg_hit(wr_addr_q, `OFS_MEAS_CTRL) && HWDATA_I[8];
    end
  end

  // read mux
  always_comb begin
    rd_data_d = 32'h0000_0000;
    if (reg_hit(HADDR_I, `OFS_PROX_GAIN)) begin
      rd_data_d = {29'h0, prox_gain_q};
    end else if (reg_hit(HADDR_I, `OFS_PROX_MISC)) begin
      rd_data_d = {26'h0, prox_range_q, 2'h0, prox_mode_q, 2'h0};
    end else if (reg_hit(HADDR_I, `OFS_AMB_IR_SEL)) begin
      rd_data_d = {24'h0, amb_ir_q};
    end else if (reg_hit(HADDR_I, `OFS_AUX_SEL)) begin
      rd_data_d = {24'h0, aux_q};
    end else if (reg_hit(HADDR_I, `OFS_VIS_REC)) begin
      rd_data_d = {25'h0, vis_rec_q, 4'h0};
    end else if (reg_hit(HADDR_I, `OFS_VIS_GAIN)) begin
      rd_data_d = {29'h0, vis_gain_q};
    end else if (reg_hit(HADDR_I, `OFS_MEAS_CTRL)) begin
      rd_data_d = {28'h0, kind_en_q};
    end else if (reg_hit(HADDR_I, `OFS_MEAS_STAT)) begin
      rd_data_d = {26'h0, done_cnt_q, kind_q, 1'b0, state_q != ST_IDLE};
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rd_data_q <= 32'h0000_0000;
    end else if (addr_phase && !HWRITE_I) begin
      rd_data_q <= (HADDR_I[31:8] == 24'h0) ? rd_data_d : 32'h0000_0000;
    end
  end

  assign HRDATA_O = rd_data_q;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;

  // sequencer
  always_comb begin
    tmr_start = 1'b0;
    tmr_clocks = 10'h000;
    tmr_exp = 3'h0;
    if (state_q == ST_IDLE && start_q && kind_en_q != 4'h0) begin
      tmr_start = 1'b1;
      tmr_clocks = rec_clocks(vis_rec_q);
      tmr_exp = vis_gain_q;
    end else if (state_q == ST_RECOVER && tmr_done) begin
      tmr_start = 1'b1;
      tmr_clocks = 10'(`BASE_INTEG_CLKS);
      // integration stretched by the proximity or visible gain exponent, ir and aux unstretched
      tmr_exp = (kind_q == MEAS_PROX) ? prox_gain_q : ((kind_q == MEAS_VIS) ? vis_gain_q : 3'h0);
    end
  end

  adc_tick_timer #(
    .CNT_W(24)
  ) u_timer (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .start_i(tmr_start),
    .clocks_i(tmr_clocks),
    .exp_i(tmr_exp),
    .busy_o(tmr_busy),
    .done_o(tmr_done)
  );

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_q <= ST_IDLE;
      kind_q <= MEAS_PROX;
      done_cnt_q <= 2'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (tmr_start) begin
            state_q <= ST_RECOVER;
            kind_q <= MEAS_VIS;
            if (kind_en_q[0]) kind_q <= MEAS_PROX;
            else if (kind_en_q[1]) kind_q <= MEAS_VIS;
            else if (kind_en_q[2]) kind_q <= MEAS_IR;
            else kind_q <= MEAS_AUX;
          end
        end
        ST_RECOVER: begin
          if (tmr_done) begin
            state_q <= ST_INTEG;
          end
        end
        ST_INTEG: begin
          if (tmr_done) begin
            state_q <= ST_NEXT;
            done_cnt_q <= done_cnt_q + 2'h1;
          end
        end
        ST_NEXT: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // front end setup reloaded every cycle from the kind and current registers
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      setup_q <= '0;
    end else begin
      setup_q.gain_exp <= (kind_q == MEAS_PROX) ? prox_gain_q : vis_gain_q;
      setup_q.high_range <= (kind_q == MEAS_PROX) && prox_range_q;
      setup_q.normal_mode <= prox_mode_q;
      // raw mode turns the emitter off; on exactly while integrating a proximity measurement
      setup_q.emitter_on <= (kind_q == MEAS_PROX) && prox_mode_q &&
        ((state_q == ST_RECOVER && tmr_done) || (state_q == ST_INTEG && !tmr_done));
      if (kind_q == MEAS_IR) begin
        setup_q.input_code <= amb_ir_q;
      end else if (kind_q == MEAS_AUX) begin
        setup_q.input_code <= aux_q;
      end else begin
        setup_q.input_code <= 8'h00;
      end
    end
  end

  assign ADC_SETUP_O = setup_q;
  assign ADC_CONVERT_O = (state_q == ST_INTEG);
  assign ADC_KIND_O = kind_q;

  // cycles spent in integration, checked against the gain at its end
  logic [12:0] integ_len_q;
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      integ_len_q <= 13'h0000;
    end else if (state_q == ST_INTEG) begin
      integ_len_q <= integ_len_q + 13'h0001;
    end else begin
      integ_len_q <= 13'h0000;
    end
  end

  // register reset and write checks
  a_misc_reset_mode: assert property (@(posedge CLK_I) $rose(NRST_I) |-> prox_mode_q)
    else $error("mode not normal after reset");
  a_range_write: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    wr_pend_q && reg_hit(wr_addr_q, `OFS_PROX_MISC) |=> prox_range_q == $past(HWDATA_I[`BIT_PROX_RANGE]))
    else $error("range bit not taken from bit 5");
  a_mode_write: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    wr_pend_q && reg_hit(wr_addr_q, `OFS_PROX_MISC) |=> prox_mode_q == $past(HWDATA_I[`BIT_PROX_MODE]))
    else $error("mode bit not taken from bit 2");
  a_gain_reserved: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    wr_pend_q && reg_hit(wr_addr_q, `OFS_PROX_GAIN) |=> prox_gain_q == $past(HWDATA_I[2:0]))
    else $error("gain field decode wrong");

  // sequencer timing checks
  a_rec_zero_len: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    state_q == ST_IDLE && tmr_start && vis_rec_q == 3'h0 && vis_gain_q == 3'h0
    |=> ##1 state_q == ST_RECOVER ##1 state_q == ST_INTEG)
    else $error("recovery of one adc clock wrong length");
  a_rec_mid_len: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    state_q == ST_IDLE && tmr_start && vis_rec_q == 3'h2 && vis_gain_q == 3'h1
    |=> ##59 state_q == ST_RECOVER ##1 state_q == ST_INTEG)
    else $error("recovery of fifteen adc clocks wrong length");
  a_rec_max_len: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    state_q == ST_IDLE && tmr_start && vis_rec_q == 3'h7 && vis_gain_q == 3'h0
    |=> state_q == ST_RECOVER [*8])
    else $error("longest recovery ended early");
  a_prox_integ: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    state_q == ST_RECOVER && tmr_done && kind_q == MEAS_PROX && prox_gain_q == 3'h0
    |=> ##31 state_q == ST_INTEG ##1 state_q == ST_NEXT)
    else $error("undivided proximity integration wrong length");
  a_vis_integ: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    state_q == ST_RECOVER && tmr_done && kind_q == MEAS_VIS && vis_gain_q == 3'h1
    |=> ##63 state_q == ST_INTEG ##1 state_q == ST_NEXT)
    else $error("visible integration not doubled");
  a_prox_gain_len: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    state_q == ST_INTEG && tmr_done && kind_q == MEAS_PROX
    |-> integ_len_q + 13'h0001 == 13'((`BASE_INTEG_CLKS * `ADC_TICK_CYC) << prox_gain_q))
    else $error("proximity integration not scaled by gain");
  a_vis_gain_len: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    state_q == ST_INTEG && tmr_done && kind_q == MEAS_VIS
    |-> integ_len_q + 13'h0001 == 13'((`BASE_INTEG_CLKS * `ADC_TICK_CYC) << vis_gain_q))
    else $error("visible integration not scaled by gain");
  a_done_count: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    state_q == ST_INTEG && tmr_done |=> done_cnt_q == 2'($past(done_cnt_q) + 2'h1))
    else $error("completed count not advanced");
  a_kind_hold: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    state_q != ST_IDLE |=> $stable(kind_q))
    else $error("kind changed during a measurement");

  // front end routing checks
  a_ir_select: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    kind_q == MEAS_IR && $stable(kind_q) && $stable(amb_ir_q) |=> setup_q.input_code == $past(amb_ir_q))
    else $error("ir input code not routed");
  a_aux_select: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    kind_q == MEAS_AUX && $stable(aux_q) |=> setup_q.input_code == $past(aux_q))
    else $error("aux input code not routed");
  a_emit_in_conv: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    setup_q.emitter_on |-> state_q == ST_INTEG && kind_q == MEAS_PROX)
    else $error("emitter on outside proximity integration");
  a_emit_raw_off: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    !prox_mode_q |=> !setup_q.emitter_on)
    else $error("emitter on in raw mode");
  a_range_prox_only: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    kind_q != MEAS_PROX |=> !setup_q.high_range)
    else $error("high range outside proximity");
  c_prox_run: cover property (@(posedge CLK_I) kind_q == MEAS_PROX && state_q == ST_INTEG);
  c_vis_run: cover property (@(posedge CLK_I) kind_q == MEAS_VIS && state_q == ST_NEXT);
  c_high_range: cover property (@(posedge CLK_I) setup_q.high_range);
  c_aux_vdd: cover property (@(posedge CLK_I) setup_q.input_code == `AUX_VDD);
  c_raw_mode: cover property (@(posedge CLK_I) state_q == ST_INTEG && !setup_q.normal_mode);
endmodule // adc_meas_ctrl

/* File: tb/tb.sv */
// testbench for the measurement configuration block
// assumes the block answers with zero wait states over ahb-lite
`timescale 1ns/1ps
`include "adc_meas_cfg.svh"
module tb
  import adc_meas_pkg::*;
;
  logic clk, nrst, hsel, hwrite, hready, hresp, conv;
  logic [1:0] htrans, kind;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, d;
  adc_setup_t setup, su;
  int mismatches, compares, done_cnt, l0, l1;
  int cyc = 0;
  logic [31:0] ofs [6] = '{`OFS_PROX_GAIN, `OFS_PROX_MISC, `OFS_AMB_IR_SEL, `OFS_AUX_SEL, `OFS_VIS_REC, `OFS_VIS_GAIN};
  logic [7:0] rstv [6] = '{`RST_PROX_GAIN, `RST_PROX_MISC, `RST_AMB_IR_SEL, `RST_AUX_SEL, `RST_VIS_REC, `RST_VIS_GAIN};
  logic [7:0] msk [6] = '{8'h07, 8'h24, 8'hFF, 8'hFF, 8'h70, 8'h07};
  logic [7:0] irc [2] = '{`AMB_IR_SMALL, `AMB_IR_LARGE};
  logic [7:0] auxc [2] = '{`AUX_TEMP, `AUX_VDD};
  int pg [3] = '{0, 4, 5};

  adc_meas_ctrl i_dut (.CLK_I(clk), .NRST_I(nrst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .ADC_SETUP_O(setup), .ADC_CONVERT_O(conv), .ADC_KIND_O(kind));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic results();
    $display("checks %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // address phase held until hready, then data phase
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {a[29:0], 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
    chk("response", 32'h0, {31'h0, hresp});
    hsel <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic [31:0] x;
    xfer(a, 1'b1, v, x);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] v);
    xfer(a, 1'b0, 32'h0000_0000, v);
  endtask

  // start one measurement, return recovery latency and captured setup
  task automatic meas(input int k, input int exp_len, output int lat);
    int n;
    lat = 0;
    n = 0;
    wr(`OFS_MEAS_CTRL, 32'h0000_0100 | (32'h1 << k));
    while (conv !== 1'b1 && lat < 40000) begin
      @(negedge clk);
      lat++;
    end
    su = setup;
    chk("kind", k, {30'h0, kind});
    while (conv === 1'b1 && n < 40000) begin
      n++;
      @(negedge clk);
    end
    chk("integration", exp_len, n);
    repeat (3) @(posedge clk);
    done_cnt++;
    rd(`OFS_MEAS_STAT, d);
    chk("status", {26'h0, done_cnt[1:0], k[1:0], 2'h0}, d & 32'h0000_003D);
  endtask

  initial begin
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    nrst = 1'b0;
    mismatches = 0;
    compares = 0;
    done_cnt = 0;
    void'($urandom(32'hef858ebf));
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(ofs[i], d);
      chk("reset value", {24'h0, rstv[i]}, d);
    end
    for (int i = 0; i < 6; i++) begin
      l0 = $urandom & msk[i];
      if (i == 0) l0 = l0 % 6;
      wr(ofs[i], l0);
      rd(ofs[i], d);
      chk("readback", {24'h0, l0[7:0] & msk[i]}, d);
    end
    rd(32'h0000_0040, d);
    chk("unmapped", 32'h0, d);
    wr(`OFS_VIS_GAIN, 32'h0);
    wr(`OFS_VIS_REC, 32'h0);
    // gains kept at five or below, nothing in the block limits them
    for (int i = 0; i < 3; i++) begin
      wr(`OFS_PROX_GAIN, pg[i]);
      wr(`OFS_PROX_MISC, (i == 1) ? 32'h24 : 32'h04);
      meas(0, 32 << pg[i], l0);
      chk("prox gain", pg[i], {29'h0, su.gain_exp});
      chk("high range", (i == 1), {31'h0, su.high_range});
      chk("normal mode", 1, {31'h0, su.normal_mode});
      chk("emitter", 1, {31'h0, su.emitter_on});
    end
    wr(`OFS_PROX_MISC, 32'h20);
    meas(0, 32 << pg[2], l0);
    chk("raw mode", 0, {31'h0, su.normal_mode});
    chk("emitter off", 0, {31'h0, su.emitter_on});
    chk("raw high range", 1, {31'h0, su.high_range});
    // recovery difference between codes cancels fixed latency
    for (int vg = 0; vg < 2; vg++) begin
      wr(`OFS_VIS_GAIN, vg);
      wr(`OFS_VIS_REC, 32'h00);
      meas(1, 32 << vg, l0);
      wr(`OFS_VIS_REC, vg ? 32'h20 : 32'h70);
      meas(1, 32 << vg, l1);
      chk("recovery", (vg ? 14 : 510) * `ADC_TICK_CYC * (1 << vg), l1 - l0);
    end
    wr(`OFS_VIS_GAIN, 32'h0);
    wr(`OFS_VIS_REC, 32'h0);
    for (int i = 0; i < 2; i++) begin
      wr(`OFS_AMB_IR_SEL, irc[i]);
      meas(2, 32, l0);
      chk("ir input", irc[i], {24'h0, su.input_code});
      wr(`OFS_AUX_SEL, auxc[i]);
      meas(3, 32, l0);
      chk("aux input", auxc[i], {24'h0, su.input_code});
    end
    results();
  end
endmodule // tb
